// [hw/urxfb_top.sv]
// Serial receiver with frame configuration and fractional baud divisor.
// Assumes a synchronous serial input and a plain strobe register port.
//
// Functional notes
// - Parity enabled with even select 0 checks for an odd count of ones in data plus parity.
// - Parity enabled with even select 1 checks for an even count; parity off expects no parity bit.
// - Stop select 0 checks one stop bit, 1 checks two stop bits.
// - FIFO enable 0 gives character mode with one holding stage, 1 buffers in the receive FIFO.
// - Word length 00b/01b/10b/11b gives five/six/seven/eight data bits.
// - Stick parity with parity on expects 0 when even select is 1 and 1 when it is 0.
// - Oversampling select 0 gives sixteen ticks per bit.
// - Oversampling select 1 gives eight ticks per bit.
// - The tick period is the 16-bit integer divisor plus the fraction.
// - New divisor values take effect only once the current character has completed.
// - The fraction is a six-bit field in bits 5:0 of its own register, in 64ths.
`timescale 1ns/1ps
`default_nettype none
module urxfb_top #(
    parameter int FIFO_WORDS = urxfb_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clkEnable,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic [31:0]      rdData,
    input  wire logic        serialIn,
    output logic             rxBusy
);
    localparam int EW = urxfb_pkg::ENTRY_WIDTH;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Expected parity bit for the received data
    function automatic logic expParity(input logic [7:0] d, input logic evenSel,
                                       input logic stick);
        logic ones;
        ones = ^d;
        if (stick) begin
            expParity = ~evenSel;
        end else if (evenSel) begin
            expParity = ones;
        end else begin
            expParity = ~ones;
        end
    endfunction

    // Ticks per bit for an oversampling select
    function automatic logic [4:0] ticksPerBit(input logic ovs);
        ticksPerBit = ovs ? urxfb_pkg::OVS_TICKS_8 : urxfb_pkg::OVS_TICKS_16;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  lineCtrl_ff;
    logic [15:0] divisor_integer_part_ff;
    logic [5:0]  divisor_fraction_part_ff;
    logic        ovsSel_ff;
    logic [15:0] actInt_ff;
    logic [5:0]  actFrac_ff;
    logic        actOvs_ff;
    logic        overrun_ff;
    logic [31:0] rdData_ff;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    logic [7:0]    frameCfg_ff;      // Line control captured at frame start
    logic [15:0]   cycCnt_ff;        // Clock cycles inside the current tick
    logic [5:0]    fracAcc_ff;       // Fraction accumulator, in 64ths
    logic          extra_ff;         // Next tick is one cycle longer
    logic [4:0]    tickCnt_ff;       // Ticks inside the current bit
    logic [2:0]    bitIdx_ff;        // Index of the next data bit
    logic [7:0]    shift_ff;         // Received data, LSB first
    logic          parErr_ff;
    logic          frameErr_ff;
    logic          prevLine_ff;      // Line level one cycle ago
    logic          holdFull_ff;
    logic [EW-1:0] holdData_ff;
    logic          busy_ff;
    urxfb_pkg::urxfb_state_t state_ff;
    urxfb_pkg::urxfb_state_t nxt_state;

    // ------------------------------------------------------------
    // Named decode wires
    // ------------------------------------------------------------
    wire logic          startEdge;
    wire logic [16:0]   periodLen;
    wire logic          tick;
    wire logic [6:0]    fracSum;
    wire logic [4:0]    bitTicks;
    wire logic [4:0]    tickTarget;
    wire logic          sampleNow;
    wire logic [2:0]    lastIdx;
    wire logic          stopBad;
    wire logic          frameDone;
    wire logic [EW-1:0] entry;
    wire logic          liveFifo;
    wire logic          frameFifo;
    wire logic          framePar;
    wire logic          frameTwo;
    wire logic          dataRead;
    wire logic          statusRead;
    wire logic          pushFifo;
    wire logic          pushHold;
    wire logic          popHold;
    wire logic          lostChar;
    wire logic          fifoInReady;
    wire logic          fifoOutValid;
    wire logic [EW-1:0] fifoOutData;
    wire logic          rxEmpty;
    wire logic          rxFull;
    wire logic [31:0]   rxDataWord;
    wire logic [31:0]   statusWord;
    wire logic [31:0]   regWord;
    wire logic          wrLine;
    wire logic          wrInt;
    wire logic          wrFrac;
    wire logic          wrCtrl;

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    // Write strobes per register
    assign wrLine     = wrStrobe && (addr == urxfb_pkg::OFF_RX_LINE_CTRL);
    assign wrInt      = wrStrobe && (addr == urxfb_pkg::OFF_DIV_INTEGER);
    assign wrFrac     = wrStrobe && (addr == urxfb_pkg::OFF_DIV_FRACTION);
    assign wrCtrl     = wrStrobe && (addr == urxfb_pkg::OFF_SERIAL_CTRL);
    assign dataRead   = rdStrobe && (addr == urxfb_pkg::OFF_RX_DATA);
    assign statusRead = rdStrobe && (addr == urxfb_pkg::OFF_RX_STATUS);

    // Software-visible registers; the frame uses captured copies
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineCtrl_ff <= urxfb_pkg::RST_LINE_CTRL;
            divisor_integer_part_ff   <= urxfb_pkg::RST_DIV_INT;
            divisor_fraction_part_ff  <= urxfb_pkg::RST_DIV_FRAC;
            ovsSel_ff   <= urxfb_pkg::RST_OVS_SEL;
        end else if (clkEnable) begin
            if (wrLine) lineCtrl_ff <= wrData[7:0];
            if (wrInt)  divisor_integer_part_ff   <= wrData[15:0];
            if (wrFrac) divisor_fraction_part_ff  <= wrData[5:0];
            if (wrCtrl) ovsSel_ff   <= wrData[urxfb_pkg::POS_OVS_SEL];
        end
    end

    // ------------------------------------------------------------
    // Frame configuration as captured at the start bit
    // ------------------------------------------------------------
    assign frameFifo = frameCfg_ff[urxfb_pkg::POS_FIFO_ON];
    assign framePar  = frameCfg_ff[urxfb_pkg::POS_PARITY_ON];
    assign frameTwo  = frameCfg_ff[urxfb_pkg::POS_TWO_STOP];
    assign liveFifo  = lineCtrl_ff[urxfb_pkg::POS_FIFO_ON];
    // Index of the last data bit: four plus the word length code, for five to eight bits
    assign lastIdx   = 3'(urxfb_pkg::MIN_DATA_BITS - 4'h1
                         + {2'b00, frameCfg_ff[urxfb_pkg::POS_WLEN_LO +: 2]});

    // Start is a falling edge only, so a held-low line after a
    // framing error does not start a phantom frame
    assign startEdge = prevLine_ff && !serialIn
                       && (state_ff == urxfb_pkg::RX_IDLE);

    // Divisor and frame settings are frozen for the whole character
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frameCfg_ff <= urxfb_pkg::RST_LINE_CTRL;
            actInt_ff   <= urxfb_pkg::RST_DIV_INT;
            actFrac_ff  <= urxfb_pkg::RST_DIV_FRAC;
            actOvs_ff   <= urxfb_pkg::RST_OVS_SEL;
        end else if (clkEnable && startEdge) begin
            frameCfg_ff <= lineCtrl_ff;
            actInt_ff   <= divisor_integer_part_ff;
            actFrac_ff  <= divisor_fraction_part_ff;
            actOvs_ff   <= ovsSel_ff;
        end
    end

    // Line history for the start edge; idle level after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevLine_ff <= 1'b1;
        end else if (clkEnable) begin
            prevLine_ff <= serialIn;
        end
    end

    // ------------------------------------------------------------
    // Oversampling tick generator
    // ------------------------------------------------------------
    // A divisor of zero, or of one with no fraction carry, gives a tick every cycle
    assign periodLen = {1'b0, actInt_ff} + {16'h0000, extra_ff};
    assign tick      = ({1'b0, cycCnt_ff} + 17'h00001) >= periodLen;
    assign fracSum   = {1'b0, fracAcc_ff} + {1'b0, actFrac_ff};

    // Carry of the fraction stretches the next tick by one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cycCnt_ff  <= 16'h0000;
            fracAcc_ff <= 6'h00;
            extra_ff   <= 1'b0;
        end else if (clkEnable) begin
            if (startEdge) begin
                cycCnt_ff  <= 16'h0000;
                fracAcc_ff <= 6'h00;
                extra_ff   <= 1'b0;
            end else if (tick) begin
                cycCnt_ff  <= 16'h0000;
                fracAcc_ff <= fracSum[5:0];
                extra_ff   <= fracSum[6];
            end else begin
                cycCnt_ff  <= cycCnt_ff + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Bit timing: half a bit into the start, then whole bits
    // ------------------------------------------------------------
    assign bitTicks   = ticksPerBit(actOvs_ff);
    assign tickTarget = (state_ff == urxfb_pkg::RX_START) ? (bitTicks >> 1) : bitTicks;
    assign sampleNow  = tick && ((tickCnt_ff + 5'h01) == tickTarget)
                        && (state_ff != urxfb_pkg::RX_IDLE);

    // Tick count inside the bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_ff <= 5'h00;
        end else if (clkEnable) begin
            if (startEdge || sampleNow) begin
                tickCnt_ff <= 5'h00;
            end else if (tick) begin
                tickCnt_ff <= tickCnt_ff + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            urxfb_pkg::RX_IDLE: begin
                if (startEdge) nxt_state = urxfb_pkg::RX_START;
            end
            urxfb_pkg::RX_START: begin
                // A high line at mid start bit was only a glitch
                if (sampleNow) nxt_state = serialIn ? urxfb_pkg::RX_IDLE : urxfb_pkg::RX_DATA;
            end
            urxfb_pkg::RX_DATA: begin
                if (sampleNow && (bitIdx_ff == lastIdx)) begin
                    nxt_state = framePar ? urxfb_pkg::RX_PARITY : urxfb_pkg::RX_STOP1;
                end
            end
            urxfb_pkg::RX_PARITY: begin
                if (sampleNow) nxt_state = urxfb_pkg::RX_STOP1;
            end
            urxfb_pkg::RX_STOP1: begin
                if (sampleNow) nxt_state = frameTwo ? urxfb_pkg::RX_STOP2 : urxfb_pkg::RX_IDLE;
            end
            urxfb_pkg::RX_STOP2: begin
                if (sampleNow) nxt_state = urxfb_pkg::RX_IDLE;
            end
            default: begin
                nxt_state = urxfb_pkg::RX_IDLE;
            end
        endcase
    end

    // State and busy flag move together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= urxfb_pkg::RX_IDLE;
            busy_ff  <= 1'b0;
        end else if (clkEnable) begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != urxfb_pkg::RX_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Data and error capture
    // ------------------------------------------------------------
    // Unused upper data bits stay zero for short words
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff  <= 8'h00;
            bitIdx_ff <= 3'h0;
        end else if (clkEnable) begin
            if (startEdge) begin
                shift_ff  <= 8'h00;
                bitIdx_ff <= 3'h0;
            end else if (sampleNow && (state_ff == urxfb_pkg::RX_DATA)) begin
                shift_ff[bitIdx_ff] <= serialIn;
                bitIdx_ff           <= bitIdx_ff + 3'h1;
            end
        end
    end

    // Parity and first stop bit checks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parErr_ff   <= 1'b0;
            frameErr_ff <= 1'b0;
        end else if (clkEnable) begin
            if (startEdge) begin
                parErr_ff   <= 1'b0;
                frameErr_ff <= 1'b0;
            end else if (sampleNow && (state_ff == urxfb_pkg::RX_PARITY)) begin
                parErr_ff <= serialIn != expParity(shift_ff,
                    frameCfg_ff[urxfb_pkg::POS_EVEN_SEL],
                    frameCfg_ff[urxfb_pkg::POS_STICK]);
            end else if (sampleNow && (state_ff == urxfb_pkg::RX_STOP1)) begin
                frameErr_ff <= !serialIn;
            end
        end
    end

    // A low level on any stop bit marks the character
    assign stopBad   = !serialIn || ((state_ff == urxfb_pkg::RX_STOP2) && frameErr_ff);
    assign frameDone = sampleNow && (((state_ff == urxfb_pkg::RX_STOP1) && !frameTwo)
                                     || (state_ff == urxfb_pkg::RX_STOP2));
    assign entry     = {parErr_ff, stopBad, shift_ff};

    // ------------------------------------------------------------
    // Receive storage: FIFO or single holding stage
    // ------------------------------------------------------------
    assign pushFifo = frameDone && frameFifo;
    assign pushHold = frameDone && !frameFifo;
    assign popHold  = dataRead && !liveFifo && holdFull_ff;
    // A character that finds no room is dropped and flagged
    assign lostChar = (pushHold && holdFull_ff && !popHold) || (pushFifo && !fifoInReady);

    urxfb_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_WORDS)
    ) rxFifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .clkEnable (clkEnable),
        .inValid   (pushFifo),
        .inReady   (fifoInReady),
        .inData    (entry),
        .outValid  (fifoOutValid),
        .outReady  (dataRead && liveFifo),
        .outData   (fifoOutData)
    );

    // Holding stage; a new character wins over a read in one cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdFull_ff <= 1'b0;
            holdData_ff <= '0;
        end else if (clkEnable) begin
            holdFull_ff <= pushHold || (holdFull_ff && !popHold);
            if (pushHold && !(holdFull_ff && !popHold)) holdData_ff <= entry;
        end
    end

    // Overrun is sticky until status is read; setting wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_ff <= 1'b0;
        end else if (clkEnable) begin
            overrun_ff <= lostChar || (overrun_ff && !statusRead);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign rxEmpty    = liveFifo ? !fifoOutValid : !holdFull_ff;
    assign rxFull     = liveFifo ? !fifoInReady : holdFull_ff;
    assign rxDataWord = liveFifo ? (fifoOutValid ? 32'(fifoOutData) : 32'h00000000)
                                 : (holdFull_ff ? 32'(holdData_ff) : 32'h00000000);
    assign statusWord = (32'(rxEmpty) << urxfb_pkg::POS_ST_EMPTY)
                      | (32'(rxFull) << urxfb_pkg::POS_ST_FULL)
                      | (32'(overrun_ff) << urxfb_pkg::POS_ST_OVERRUN)
                      | (32'(busy_ff) << urxfb_pkg::POS_ST_BUSY);
    // Unmapped offsets read as zero
    assign regWord =
        (addr == urxfb_pkg::OFF_RX_DATA)      ? rxDataWord :
        (addr == urxfb_pkg::OFF_RX_STATUS)    ? statusWord :
        (addr == urxfb_pkg::OFF_RX_LINE_CTRL) ? 32'(lineCtrl_ff) :
        (addr == urxfb_pkg::OFF_DIV_INTEGER)  ? 32'(divisor_integer_part_ff) :
        (addr == urxfb_pkg::OFF_DIV_FRACTION) ? 32'(divisor_fraction_part_ff) :
        (addr == urxfb_pkg::OFF_SERIAL_CTRL)  ? (32'(ovsSel_ff) << urxfb_pkg::POS_OVS_SEL) :
                                                32'h00000000;

    // Read data stands in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_ff <= 32'h00000000;
        end else if (clkEnable && rdStrobe) begin
            rdData_ff <= regWord;
        end
    end

    assign rdData = rdData_ff;
    assign rxBusy = busy_ff;
endmodule
`default_nettype wire

// [common/urxfb_pkg.sv]
// Constants shared by the serial receive frame and baud block.
// Assumes byte addresses on a plain strobe port with 32-bit data.
`default_nettype none
package urxfb_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_RX_DATA       = 8'h00;
    localparam logic [7:0] OFF_RX_STATUS     = 8'h04;
    localparam logic [7:0] OFF_RX_LINE_CTRL  = 8'h1c;
    localparam logic [7:0] OFF_DIV_INTEGER   = 8'h24;
    localparam logic [7:0] OFF_DIV_FRACTION  = 8'h28;
    localparam logic [7:0] OFF_SERIAL_CTRL   = 8'h30;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_PARITY_ON   = 1;
    localparam int POS_EVEN_SEL    = 2;
    localparam int POS_TWO_STOP    = 3;
    localparam int POS_FIFO_ON     = 4;
    localparam int POS_WLEN_LO     = 5;
    localparam int POS_STICK       = 7;
    localparam int POS_OVS_SEL     = 0;
    localparam int POS_ST_EMPTY    = 0;
    localparam int POS_ST_FULL     = 1;
    localparam int POS_ST_OVERRUN  = 2;
    localparam int POS_ST_BUSY     = 3;
    localparam int POS_D_FRAME_ERR = 8;
    localparam int POS_D_PAR_ERR   = 9;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_LINE_CTRL = 8'h00;
    localparam logic [15:0] RST_DIV_INT   = 16'h0000;
    localparam logic [5:0]  RST_DIV_FRAC  = 6'h00;
    localparam logic        RST_OVS_SEL   = 1'h0;
    localparam logic [4:0]  OVS_TICKS_16  = 5'h10;
    localparam logic [4:0]  OVS_TICKS_8   = 5'h08;
    localparam logic [3:0]  MIN_DATA_BITS = 4'h5;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          ENTRY_WIDTH   = 10;

    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP1, RX_STOP2
    } urxfb_state_t;
endpackage
`default_nettype wire

// [hw/urxfb_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; clkEnable low freezes all state.
`timescale 1ns/1ps
`default_nettype none
module urxfb_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clkEnable,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_ff;
    logic [AW:0]      rdPtr_ff;
    logic [AW:0]      nxt_wrPtr;
    logic [AW:0]      nxt_rdPtr;
    wire  logic       doPush;
    wire  logic       doPop;

    // ------------------------------------------------------------
    // Flags from pointers; extra bit tells full from empty
    // ------------------------------------------------------------
    assign outValid  = (wrPtr_ff != rdPtr_ff);
    assign inReady   = (wrPtr_ff[AW] == rdPtr_ff[AW]) || (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
    assign doPush    = inValid && inReady && clkEnable;
    assign doPop     = outValid && outReady && clkEnable;
    assign nxt_wrPtr = wrPtr_ff + (AW+1)'(1);
    assign nxt_rdPtr = rdPtr_ff + (AW+1)'(1);
    assign outData   = mem[rdPtr_ff[AW-1:0]];

    // Pointer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (doPush) wrPtr_ff <= nxt_wrPtr;
            if (doPop)  rdPtr_ff <= nxt_rdPtr;
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (doPush) mem[wrPtr_ff[AW-1:0]] <= inData;
    end
endmodule
`default_nettype wire

// [verification/urxfb_checker.sv]
// Port checks for the serial receive block.
// Assumes a bind into urxfb_top and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module urxfb_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic        serialIn,
    input wire logic        rxBusy,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wrData,
    input wire logic [31:0] rdData
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Written fields read back: write, idle cycle, read, then data
    chk_ctrl_readback: assert property (wrStrobe && addr == 8'h1c ##2 rdStrobe && addr == 8'h1c
        |=> rdData[7:0] == $past(wrData[7:0], 3)) else $error("line control readback");
    chk_div_readback: assert property (wrStrobe && addr == 8'h24 ##2 rdStrobe && addr == 8'h24
        |=> rdData[15:0] == $past(wrData[15:0], 3)) else $error("divisor readback");
    chk_frac_readback: assert property (wrStrobe && addr == 8'h28 ##2 rdStrobe && addr == 8'h28
        |=> rdData[5:0] == $past(wrData[5:0], 3)) else $error("fraction readback");
    chk_busy_mirror: assert property (rdStrobe && addr == 8'h04
        |=> rdData[3] == $past(rxBusy)) else $error("status busy bit");
    // A frame only starts on a low line and lasts many cycles
    chk_busy_start: assert property ($rose(rxBusy)
        |-> !$past(serialIn) || !$past(serialIn, 2) || !$past(serialIn, 3)) else $error("busy start");
    chk_busy_hold: assert property ($rose(rxBusy) |-> rxBusy [*8]) else $error("busy short");
    chk_idle_reset: assert property ($rose(reset_n) |-> !rxBusy) else $error("busy at reset");
    chk_ovs_readback: assert property (wrStrobe && addr == 8'h30 ##2 rdStrobe && addr == 8'h30
        |=> rdData[0] == $past(wrData[0], 3)) else $error("oversampling readback");
endmodule
bind urxfb_top urxfb_checker chk (.clk, .reset_n, .wrStrobe, .rdStrobe, .serialIn, .rxBusy,
    .addr, .wrData, .rdData);
`default_nettype wire

// [verification/urxfb_remote_tx.sv]
// Remote serial transmitter on the receive line.
// Assumes bit times in whole clock cycles; par below zero sends no parity bit.
`timescale 1ns/1ps
`default_nettype none
module urxfb_remote_tx (
    input wire logic clk,
    output logic     line
);
    initial line = 1'b1; // Idle high between frames
    // Start, data LSB first, parity, stops; last stop may be forced low
    task automatic send(input logic [7:0] d, input int nb, par, ns, bc, input logic sv);
        for (int k = 0; k < 1 + nb + (par >= 0) + ns; k++) begin
            line <= (k == 0) ? 1'b0 : (k <= nb) ? d[k-1] : (par >= 0 && k == nb + 1) ? par[0]
                : (k == nb + (par >= 0) + ns) ? sv : 1'b1;
            repeat (bc) @(posedge clk);
        end
        line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [verification/urxfb_top_test.sv]
// Self-checking bench for the serial receive block.
// Assumes reads return data in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module urxfb_top_test;
    logic clk = 1'b0, reset_n = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0, rdPend = 1'b0, rxBusy;
    logic [7:0] addr = 8'h00, d, lc;
    logic ep, pe;
    logic [31:0] wrData = 32'h0, rdData, notes[$];
    wire logic serialIn;
    int errors = 0, samples_checked = 0, pb, nb;
    always #5 clk = ~clk;
    urxfb_top dut (.clk, .reset_n, .clkEnable(1'b1), .addr, .wrData, .wrStrobe, .rdStrobe,
        .rdData, .serialIn, .rxBusy);
    urxfb_remote_tx far (.clk, .line(serialIn));
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value rdData expected %h seen %h", exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) {addr, wrData, wrStrobe} <= {a, v, 1'b1};
        @(posedge clk) wrStrobe <= 1'b0;
    endtask
    // The expected value is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        @(posedge clk) {addr, rdStrobe} <= {a, 1'b1};
        @(posedge clk) rdStrobe <= 1'b0;
    endtask
    task automatic idle();
        for (int n = 0; rxBusy !== 1'b0; n++) begin
            if (n > 5000) begin errors++; end_of_test(); end
            @(posedge clk);
        end
    endtask
    always @(posedge clk) begin
        if (rdPend) chk(rdData, notes.pop_front());
        rdPend <= rdStrobe;
    end
    initial begin
        void'($urandom(58));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h1c, 32'h0); rd(8'h24, 32'h0); rd(8'h28, 32'h0); rd(8'h3c, 32'h0);
        d = 8'($urandom); wr(8'h24, {16'h0, d, 8'h5a}); rd(8'h24, {16'h0, d, 8'h5a});
        wr(8'h28, {26'h0, d[5:0]}); rd(8'h28, {26'h0, d[5:0]}); wr(8'h28, 32'h0);
        wr(8'h24, 32'h2);
        $display("registers done");
        // Every word length, parity mode, stop count and rate
        for (int m = 0; m < 80; m++) begin
            pb = (m / 4) % 5;
            nb = 5 + m % 4;
            lc = {pb > 2, 2'(m % 4), m / 20 % 2 == 0, m / 20 % 2 == 1, pb == 2 || pb == 4, pb != 0, 1'b0};
            wr(8'h30, 32'(m / 40)); rd(8'h30, 32'(m / 40));
            wr(8'h1c, {24'h0, lc}); rd(8'h1c, {24'h0, lc});
            d = 8'($urandom) & 8'((1 << nb) - 1);
            pb = pb == 0 ? -1 : pb > 2 ? int'(!lc[2]) : int'((^d) ^ !lc[2]) ^ ($urandom % 4 == 0);
            lc[0] = 1'($urandom % 5 != 0);
            ep = lc[7] ? !lc[2] : (^d) ^ !lc[2];
            pe = pb >= 0 && pb[0] != ep;
            far.send(d, nb, pb, 1 + m / 20 % 2, m < 40 ? 32 : 16, lc[0]);
            idle();
            rd(8'h00, {22'h0, pe, !lc[0], d});
        end
        rd(8'h04, 32'h1);
        $display("frames done");
        // Divisor rewrite mid-frame waits for the frame's end
        wr(8'h1c, 32'h60); rd(8'h1c, 32'h60);
        fork
            far.send(8'h15, 8, -1, 1, 16, 1'b1);
            begin repeat (40) @(posedge clk); wr(8'h24, 32'h3); end
        join
        idle(); rd(8'h00, 32'h15);
        far.send(8'h2a, 8, -1, 1, 24, 1'b1);
        idle(); rd(8'h00, 32'h2a);
        repeat (4) @(posedge clk);
        $display("divisor change done");
        end_of_test();
    end
endmodule
`default_nettype wire
